// ==== core/drt_defines.vh ====
/*
 * Constants of the dual 8-bit reload timer pair: register indices,
 * control field positions, reset values and prescaler width.
 * Assumes includers use the byte address = 4 * register index.
 */
`ifndef DRT_DEFINES_VH
`define DRT_DEFINES_VH

// Register indices (byte address is four times the index)
`define DRT_IDX_A_COUNTER   8'h68
`define DRT_IDX_B_COUNTER   8'h69
`define DRT_IDX_A_RELOAD    8'h6A
`define DRT_IDX_B_RELOAD    8'h6B
`define DRT_IDX_A_CONTROL   8'h6C
`define DRT_IDX_B_CONTROL   8'h6D
`define DRT_IDX_COMB_CNT    8'h6E
`define DRT_IDX_COMB_RLD    8'h6F

// Control field positions
`define DRT_SEL_HI          2
`define DRT_RUN_BIT         3
`define DRT_WIDE_BIT        4
`define DRT_PWM_BIT         5
`define DRT_LEVEL_BIT       7

// Reset values and bits that always read as one
`define DRT_A_CTL_RESET     8'h70
`define DRT_B_CTL_RESET     8'h40
`define DRT_A_CTL_ONES      8'h70
`define DRT_B_CTL_ONES      8'h40

// Count-clock select codes for the event pin
`define DRT_SEL_EV_RISE     3'h6
`define DRT_SEL_EV_FALL     3'h7

// Prescaler width: divide by 256 needs eight bits
`define DRT_PRE_W           8

`endif

// ==== core/drt_evsync.v ====
/*
 * Event pin synchroniser with edge pulses.
 * Assumes the pin is asynchronous to pclk; pulses last one enabled cycle.
 */
`timescale 1ns/1ps
module drt_evsync (
   // Clock, reset, enable
   input  wire pclk,
   input  wire presetn,
   input  wire ce,
   // Pin and edge pulses
   input  wire pin,
   output wire rise,
   output wire fall
);

   reg [2:0] sync_q;   // Three-stage pin chain
   reg       level_q;  // Last agreed level
   reg       armed_q;  // Pin has settled once since reset

   // Stage 1 feeds only stage 2; stages 2 and 3 must agree
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_q  <= 3'h0;
         level_q <= 1'b0;
         armed_q <= 1'b0;
      end else if (ce) begin
         sync_q <= {sync_q[1:0], pin};
         if (sync_q[1] == sync_q[2]) begin
            level_q <= sync_q[2];
            armed_q <= 1'b1;
         end
      end
   end

   // Edge pulses, each qualifying edge seen exactly once; the first
   // settled level after reset is the reset zero of the chain, so a pin
   // idling high gives one rise once its level reaches stage 3
   assign rise = ce & armed_q & (sync_q[1] == sync_q[2]) &
                 sync_q[2] & ~level_q;
   assign fall = ce & armed_q & (sync_q[1] == sync_q[2]) &
                 ~sync_q[2] & level_q;

endmodule

// ==== core/drt_prescale.v ====
/*
 * Timebase prescaler: one-cycle ticks at 1/1, 1/2, 1/4, 1/8, 1/32
 * and 1/256 of the enabled pclk. Assumes pclk is the timebase clock.
 */
`timescale 1ns/1ps
`include "drt_defines.vh"
module drt_prescale (
   // Clock, reset, enable
   input  wire       pclk,
   input  wire       presetn,
   input  wire       ce,
   // Tick strobes, index = select code
   output wire [5:0] tick
);

   reg [`DRT_PRE_W-1:0] div_q;  // Free-running divider

   // Divider advances only while enabled
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_q <= {`DRT_PRE_W{1'b0}};
      end else if (ce) begin
         div_q <= div_q + 1'b1;
      end
   end

   // Tick when the low bits of the divider are all ones
   localparam [47:0] TAPS = {8'd8, 8'd5, 8'd3, 8'd2, 8'd1, 8'd0};
   genvar g;
   generate
      for (g = 0; g < 6; g = g + 1) begin : g_tap
         if (g == 0) begin : g_full
            assign tick[g] = ce;
         end else begin : g_div
            assign tick[g] = ce &
               (&div_q[TAPS[g*8 +: 8]-1:0]);
         end
      end
   endgenerate

endmodule

// ==== core/drt_top.v ====
/*
 * Dual 8-bit auto-reload timer pair with 16-bit and PWM modes,
 * reached over APB. Assumes pclk is the timebase clock, event pins
 * are asynchronous, and pin direction setup lives outside.
 */
// The APB slave port was decided locally.
`timescale 1ns/1ps
`include "drt_defines.vh"
module drt_top #(
   parameter AW = 12               // APB address width
) (
   // APB clock, reset and clock enable
   input  wire          pclk,
   input  wire          presetn,
   input  wire          ce,
   // APB slave
   input  wire          psel,
   input  wire          penable,
   input  wire          pwrite,
   input  wire [AW-1:0] paddr,
   input  wire [31:0]   pwdata,
   input  wire [3:0]    pstrb,
   output reg  [31:0]   prdata,
   output reg           pready,
   output reg           pslverr,
   // Event pins
   input  wire          timer_a_event_pin,
   input  wire          timer_b_event_pin,
   // Output pins and overflow requests
   output reg           timer_a_out_q,
   output reg           timer_b_out_q,
   output reg           ovf_a_req_q,
   output reg           ovf_b_req_q
);

   ////////////////////////////////////////////////////////////////////
   // State
   reg [7:0] cnt_a_q;   // Timer A counter
   reg [7:0] cnt_b_q;   // Timer B counter
   reg [7:0] rld_a_q;   // Timer A reload
   reg [7:0] rld_b_q;   // Timer B reload
   reg [7:0] ctl_a_q;   // Timer A control, stored bits only
   reg [7:0] ctl_b_q;   // Timer B control, stored bits only
   reg       pwm_q;     // PWM flip-flop

   ////////////////////////////////////////////////////////////////////
   // Count clocks
   wire [5:0] tick;     // Prescaler ticks
   wire       ev_a_r;   // Event A rising
   wire       ev_a_f;   // Event A falling
   wire       ev_b_r;   // Event B rising
   wire       ev_b_f;   // Event B falling

   drt_prescale u_pre (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .tick    (tick)
   );

   drt_evsync u_ev_a (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .pin     (timer_a_event_pin),
      .rise    (ev_a_r),
      .fall    (ev_a_f)
   );

   drt_evsync u_ev_b (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .pin     (timer_b_event_pin),
      .rise    (ev_b_r),
      .fall    (ev_b_f)
   );

   // Count-clock decode, shared by both timers
   function sel_tick;
      input [2:0] sel;
      input [5:0] tk;
      input       rise;
      input       fall;
      begin
         case (sel)
            `DRT_SEL_EV_RISE: sel_tick = rise;
            `DRT_SEL_EV_FALL: sel_tick = fall;
            default:          sel_tick = tk[sel];
         endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Mode and count decode
   wire wide = ctl_b_q[`DRT_WIDE_BIT];   // 16-bit mode
   wire pwm  = ctl_b_q[`DRT_PWM_BIT];    // PWM mode
   wire run_a = ctl_a_q[`DRT_RUN_BIT];   // Timer A running
   wire joined = wide | pwm;             // Either joined mode

   // A counts on its selected clock while run is set
   wire inc_a = run_a & sel_tick(ctl_a_q[`DRT_SEL_HI:0], tick,
                                  ev_a_r, ev_a_f);
   wire ovf_a = inc_a & (&cnt_a_q);

   // B uses the same select coding
   wire tick_b = sel_tick(ctl_b_q[`DRT_SEL_HI:0], tick,
                          ev_b_r, ev_b_f);

   // wide mode counts A overflows; started by A run
   // PWM uses A run; B run otherwise
   // B select and run ignored in wide mode
   wire inc_b = wide ? ovf_a :
                pwm  ? (run_a & tick_b) :
                       (ctl_b_q[`DRT_RUN_BIT] & tick_b);
   wire ovf_b = inc_b & (&cnt_b_q);

   ////////////////////////////////////////////////////////////////////
   // APB decode
   wire [7:0] idx  = paddr[9:2];                  // Register index
   wire       hit  = (paddr[AW-1:10] == {(AW-10){1'b0}}) &&
                     (paddr[1:0] == 2'h0);        // In-window, aligned
   wire       acc  = psel & penable & pready;     // Completing access
   wire       wr   = acc & pwrite & hit & pstrb[0];
   wire       wr16 = wr & pstrb[1];               // Both low lanes

   // Register lookup; unmapped addresses report an error
   reg [15:0] rd_val;   // Read value
   reg        rd_ok;    // Address decodes
   always @* begin
      rd_ok  = hit;
      rd_val = 16'h0000;
      case (idx)
         `DRT_IDX_A_COUNTER: rd_val = {8'h00, cnt_a_q};
         `DRT_IDX_B_COUNTER: rd_val = {8'h00, cnt_b_q};
         `DRT_IDX_A_RELOAD:  rd_val = {8'h00, rld_a_q};
         `DRT_IDX_B_RELOAD:  rd_val = {8'h00, rld_b_q};
         // Unused A bits read as one
         `DRT_IDX_A_CONTROL: rd_val = {8'h00,
                                       ctl_a_q | `DRT_A_CTL_ONES};
         `DRT_IDX_B_CONTROL: rd_val = {8'h00,
                                       ctl_b_q | `DRT_B_CTL_ONES};
         `DRT_IDX_COMB_CNT:  rd_val = {cnt_b_q, cnt_a_q};
         `DRT_IDX_COMB_RLD:  rd_val = {rld_b_q, rld_a_q};
         default:            rd_ok  = 1'b0;
      endcase
   end

   // Write strobes per register
   wire w_cnt_a = wr & (idx == `DRT_IDX_A_COUNTER);
   wire w_cnt_b = wr & (idx == `DRT_IDX_B_COUNTER);
   wire w_rld_a = wr & (idx == `DRT_IDX_A_RELOAD);
   wire w_rld_b = wr & (idx == `DRT_IDX_B_RELOAD);
   wire w_ctl_a = wr & (idx == `DRT_IDX_A_CONTROL);
   wire w_ctl_b = wr & (idx == `DRT_IDX_B_CONTROL);
   wire w_c_cnt = wr16 & (idx == `DRT_IDX_COMB_CNT);
   wire w_c_rld = wr16 & (idx == `DRT_IDX_COMB_RLD);

   ////////////////////////////////////////////////////////////////////
   // APB response: one wait state, outputs from flip-flops
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end else if (ce) begin
         // Ready pulses in the second access cycle
         pready  <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & ~rd_ok;
         if (psel & penable & ~pready & ~pwrite) begin
            prdata <= {16'h0000, rd_val};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Counters: software write, reload, or increment
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_a_q <= 8'h00;
         cnt_b_q <= 8'h00;
      end else if (ce) begin
         // Timer A: written value wins over counting
         if (w_cnt_a | w_c_cnt) begin
            cnt_a_q <= pwdata[7:0];
         end else if (joined & ovf_b) begin
            // B overflow reloads both in joined modes
            cnt_a_q <= rld_a_q;
         end else if (~joined & ovf_a) begin
            // 8-bit mode reload on own overflow
            cnt_a_q <= rld_a_q;
         end else if (inc_a) begin
            // increment; wide mode wraps without reload
            cnt_a_q <= cnt_a_q + 8'h01;
         end
         // Timer B
         if (w_cnt_b | w_c_cnt) begin
            cnt_b_q <= w_c_cnt ? pwdata[15:8] : pwdata[7:0];
         end else if (ovf_b) begin
            // B overflow reloads B in every mode
            cnt_b_q <= rld_b_q;
         end else if (inc_b) begin
            cnt_b_q <= cnt_b_q + 8'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Reload registers
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rld_a_q <= 8'h00;
         rld_b_q <= 8'h00;
      end else if (ce) begin
         // separate reload write for a different value
         if (w_cnt_a | w_rld_a | w_c_cnt | w_c_rld) begin
            rld_a_q <= pwdata[7:0];
         end
         if (w_cnt_b | w_rld_b) begin
            rld_b_q <= pwdata[7:0];
         end else if (w_c_cnt | w_c_rld) begin
            rld_b_q <= pwdata[15:8];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Control registers and output levels
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl_a_q <= `DRT_A_CTL_RESET & ~`DRT_A_CTL_ONES;
         ctl_b_q <= `DRT_B_CTL_RESET & ~`DRT_B_CTL_ONES;
      end else if (ce) begin
         // A level written sets starting output
         if (w_ctl_a) begin
            ctl_a_q <= pwdata[7:0] & ~`DRT_A_CTL_ONES;
         end else if (ovf_a & ~pwm) begin
            ctl_a_q[`DRT_LEVEL_BIT] <= ~ctl_a_q[`DRT_LEVEL_BIT];
         end
         if (w_ctl_b) begin
            ctl_b_q <= pwdata[7:0] & ~`DRT_B_CTL_ONES;
         end else if (ovf_b & ~pwm) begin
            ctl_b_q[`DRT_LEVEL_BIT] <= ~ctl_b_q[`DRT_LEVEL_BIT];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // PWM flip-flop
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwm_q <= 1'b0;
      end else if (ce) begin
         if (~pwm | ~run_a) begin
            // Idle: B pin shows its programmed start level
            pwm_q <= ~ctl_b_q[`DRT_LEVEL_BIT];
         end else if (ovf_b) begin
            // reset wins over a simultaneous set
            pwm_q <= 1'b0;
         end else if (ovf_a) begin
            pwm_q <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Pins and overflow requests, all registered
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_a_out_q <= 1'b0;
         timer_b_out_q <= 1'b0;
         ovf_a_req_q   <= 1'b0;
         ovf_b_req_q   <= 1'b0;
      end else if (ce) begin
         if (pwm) begin
            // true phase on A, complement on B
            timer_a_out_q <= pwm_q;
            timer_b_out_q <= ~pwm_q;
         end else begin
            timer_a_out_q <= ctl_a_q[`DRT_LEVEL_BIT];
            timer_b_out_q <= ctl_b_q[`DRT_LEVEL_BIT];
         end
         ovf_a_req_q <= ovf_a;
         ovf_b_req_q <= ovf_b;
      end
   end

endmodule

// ==== dv/drt_top_asserts.sv ====
/* Checker for drt_top: APB timing and decode, overflow pulses,
   pin toggles, wide pairing, PWM complement.
   Assumes it is bound to the ports of drt_top. */
`timescale 1ns/1ps
module drt_asserts #(
   parameter AW = 12
) (
   // Clock and reset
   input wire          pclk,
   input wire          presetn,
   // APB
   input wire          psel,
   input wire          penable,
   input wire          pwrite,
   input wire [AW-1:0] paddr,
   input wire [31:0]   pwdata,
   input wire [3:0]    pstrb,
   input wire [31:0]   prdata,
   input wire          pready,
   input wire          pslverr,
   // Pins and requests
   input wire          timer_a_out_q,
   input wire          timer_b_out_q,
   input wire          ovf_a_req_q,
   input wire          ovf_b_req_q
);
   // Mode seen in writes to B control: [0] wide, [1] pwm
   reg  [1:0] mode_q;
   // Address is aligned and inside the register window
   wire       map_ok = paddr[AW-1:10] == 0 && paddr[1:0] == 2'h0 &&
                       paddr[9:2] >= 8'h68 && paddr[9:2] <= 8'h6F;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////////////////////////////
   // Follow the mode bits from accepted writes
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q <= 2'h0;
      end else if (psel && penable && pready && pwrite && pstrb[0] &&
                   map_ok && paddr[9:2] == 8'h6D) begin
         mode_q <= pwdata[5:4];
      end
   end
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_answer;
      (penable && !pready) ##1 (penable && pready);
   endsequence
   property p_one_wait;
      s_setup |-> ##1 s_answer;
   endproperty
   a_one_wait: assert property (p_one_wait)
      else $error("access wait state wrong");
   property p_rdy_pulse;
      pready |=> !pready;
   endproperty
   a_rdy_pulse: assert property (p_rdy_pulse)
      else $error("ready longer than a cycle");
   property p_err_map;
      pready |-> pslverr == !map_ok;
   endproperty
   a_err_map: assert property (p_err_map)
      else $error("error flag disagrees with decode");
   property p_bit6;
      pready && !pwrite && map_ok && paddr[9:2] == 8'h6D |-> prdata[6];
   endproperty
   a_bit6: assert property (p_bit6)
      else $error("B control bit 6 read as zero");
   property p_ovfa_pulse;
      ovf_a_req_q |=> !ovf_a_req_q;
   endproperty
   a_ovfa_pulse: assert property (p_ovfa_pulse)
      else $error("A request longer than a cycle");
   property p_ovfb_pulse;
      ovf_b_req_q |=> !ovf_b_req_q;
   endproperty
   a_ovfb_pulse: assert property (p_ovfb_pulse)
      else $error("B request longer than a cycle");
   property p_tog_a;
      !mode_q[1] && ovf_a_req_q && !psel && !$past(psel) &&
      !$past(psel, 2) |=> timer_a_out_q != $past(timer_a_out_q);
   endproperty
   a_tog_a: assert property (p_tog_a)
      else $error("A pin did not flip after overflow");
   property p_tog_b;
      !mode_q[1] && ovf_b_req_q && !psel && !$past(psel) &&
      !$past(psel, 2) |=> timer_b_out_q != $past(timer_b_out_q);
   endproperty
   a_tog_b: assert property (p_tog_b)
      else $error("B pin did not flip after overflow");
   property p_wide_pair;
      mode_q == 2'h1 && ovf_b_req_q |-> ovf_a_req_q;
   endproperty
   a_wide_pair: assert property (p_wide_pair)
      else $error("wide B overflow without A overflow");
   property p_pwm_comp;
      mode_q[1] && $past(mode_q[1], 3) |-> timer_b_out_q != timer_a_out_q;
   endproperty
   a_pwm_comp: assert property (p_pwm_comp)
      else $error("PWM pins not complementary");
endmodule
bind drt_top drt_asserts #(.AW(AW)) u_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
   .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .timer_a_out_q(timer_a_out_q), .timer_b_out_q(timer_b_out_q),
   .ovf_a_req_q(ovf_a_req_q), .ovf_b_req_q(ovf_b_req_q));

// ==== dv/drt_evt_model.sv ====
/* Event pin source for the timer pair bench.
   Assumes pulse() is called just after a rising edge. */
`timescale 1ns/1ps
module drt_evt_model (
   // Clock
   input wire pclk,
   // Event pins, idle high as with a pull-up
   output reg ev_a,
   output reg ev_b
);
   initial begin
      ev_a = 1'b1;
      ev_b = 1'b1;
   end
   // One low pulse: a fall then a rise, each held six cycles
   task automatic pulse(input bit b);
      if (b) ev_b <= 1'b0;
      else ev_a <= 1'b0;
      repeat (6) @(posedge pclk);
      if (b) ev_b <= 1'b1;
      else ev_a <= 1'b1;
      repeat (6) @(posedge pclk);
   endtask
endmodule

// ==== dv/tb_dual_8bit_reload_timer_pair.sv ====
/* Self-checking bench for the dual reload timer pair.
   Assumes drt_top, its bound checker and drt_evt_model. */
`timescale 1ns/1ps
`include "drt_defines.vh"
module tb_dual_8bit_reload_timer_pair;
   // Clock, reset and APB drive
   reg         pclk    = 1'b0;
   reg         presetn = 1'b0;
   reg         psel    = 1'b0;
   reg         penable = 1'b0;
   reg         pwrite  = 1'b0;
   reg  [11:0] paddr   = 12'h000;
   reg  [31:0] pwdata  = 32'h0;
   reg         ce      = 1'b1;
   // Design answers and pins
   wire [31:0] prdata;
   wire        pready, pslverr, pin_a, pin_b, req_a, req_b, ev_a, ev_b;
   // Last read word and error flag
   reg  [31:0] rd;
   reg         er;
   // Tallies, overflow counts, prescaler ratios
   int         err_count, comparisons, n_a, n_b;
   int         dv [6] = '{1, 2, 4, 8, 32, 256};
   always #10 pclk = ~pclk;
   // Count overflow requests
   always @(posedge pclk) begin
      if (req_a === 1'b1) n_a++;
      if (req_b === 1'b1) n_b++;
   end
   drt_top #(.AW(12)) uut (
      .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .timer_a_event_pin(ev_a),
      .timer_b_event_pin(ev_b), .timer_a_out_q(pin_a),
      .timer_b_out_q(pin_b), .ovf_a_req_q(req_a), .ovf_b_req_q(req_b));
   drt_evt_model u_ev (.pclk(pclk), .ev_a(ev_a), .ev_b(ev_b));
   ////////////////////////////////////////////////////////////////
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input [31:0] g, input [31:0] e);
      comparisons++;
      if (g !== e) begin
         err_count++;
         $display("FAIL t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic chkb(input g, input e);
      comparisons++;
      if (g !== e) begin
         err_count++;
         $display("FAIL t=%0t pin %b exp %b", $time, g, e);
      end
   endtask
   // One transfer, held until ready, then one idle edge
   task automatic apb(input w, input [7:0] i, input [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {2'h0, i, 2'h0};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input [7:0] i, input [31:0] d);
      apb(1'b1, i, d);
   endtask
   task automatic rdc(input [7:0] i, input [31:0] e);
      apb(1'b0, i, 32'h0);
      chk(rd, e);
   endtask
   // Cycles until the next overflow request of a timer
   task automatic wov(input [7:0] t, output int c);
      c = 0;
      do begin
         @(posedge pclk);
         c++;
      end while ((t[0] ? req_b : req_a) !== 1'b1);
   endtask
   ////////////////////////////////////////////////////////////////
   task automatic t_regs;
      rdc(`DRT_IDX_B_CONTROL, 32'h40);
      rdc(`DRT_IDX_A_CONTROL, 32'h70);
      wr(`DRT_IDX_B_CONTROL, 32'h07);
      rdc(`DRT_IDX_B_CONTROL, 32'h47);
      wr(`DRT_IDX_B_CONTROL, 32'h00);
      rdc(`DRT_IDX_B_CONTROL, 32'h40);
      wr(`DRT_IDX_A_COUNTER, 32'h5A);
      rdc(`DRT_IDX_A_RELOAD, 32'h5A);
      wr(`DRT_IDX_A_RELOAD, 32'h33);
      rdc(`DRT_IDX_A_COUNTER, 32'h5A);
      wr(`DRT_IDX_B_COUNTER, 32'hC3);
      rdc(`DRT_IDX_B_RELOAD, 32'hC3);
      wr(`DRT_IDX_COMB_CNT, 32'h1234);
      rdc(`DRT_IDX_COMB_RLD, 32'h1234);
      apb(1'b0, 8'h10, 32'h0);
      chkb(er, 1'b1);
      $display("t_regs done");
   endtask
   task automatic t_presc;
      logic [7:0] t;
      int c, k;
      for (t = 0; t < 2; t++) begin
         for (k = 0; k < 6; k++) begin
            wr(`DRT_IDX_A_COUNTER + t, 32'hFE);
            wr(`DRT_IDX_A_CONTROL + t, 32'h08 | k);
            wov(t, c);
            wov(t, c);
            chk(c, 2 * dv[k]);
            wr(`DRT_IDX_A_CONTROL + t, 32'h0);
         end
      end
      $display("t_presc done");
   endtask
   // Clock enable low freezes counting and requests
   task automatic t_hold;
      int c, a0;
      wr(`DRT_IDX_A_COUNTER, 32'hFE);
      wr(`DRT_IDX_A_CONTROL, 32'h08);
      wov(0, c);
      ce <= 1'b0;
      @(posedge pclk);
      a0 = n_a;
      repeat (9) @(posedge pclk);
      chk(n_a - a0, 0);
      ce <= 1'b1;
      wov(0, c);
      chk(c, 2);
      wr(`DRT_IDX_A_CONTROL, 32'h0);
      $display("t_hold done");
   endtask
   task automatic t_event;
      logic [7:0] t, s;
      for (t = 0; t < 2; t++) begin
         for (s = 6; s < 8; s++) begin
            wr(`DRT_IDX_A_COUNTER + t, 32'hFE);
            wr(`DRT_IDX_A_RELOAD + t, 32'h10);
            wr(`DRT_IDX_A_CONTROL + t, 32'h88 | s);
            @(posedge pclk);
            chkb(t[0] ? pin_b : pin_a, 1'b1);
            u_ev.pulse(t[0]);
            repeat (8) @(posedge pclk);
            rdc(`DRT_IDX_A_COUNTER + t, 32'hFF);
            u_ev.pulse(t[0]);
            repeat (8) @(posedge pclk);
            rdc(`DRT_IDX_A_COUNTER + t, 32'h10);
            chkb(t[0] ? pin_b : pin_a, 1'b0);
            rdc(`DRT_IDX_A_CONTROL + t, (t[0] ? 32'h48 : 32'h78) | s);
            wr(`DRT_IDX_A_CONTROL + t, s);
            u_ev.pulse(t[0]);
            rdc(`DRT_IDX_A_COUNTER + t, 32'h10);
         end
      end
      $display("t_event done");
   endtask
   task automatic t_wide;
      int c, b0;
      wr(`DRT_IDX_B_CONTROL, 32'h18);
      wr(`DRT_IDX_COMB_CNT, 32'hFFFF);
      wr(`DRT_IDX_COMB_RLD, 32'h12F0);
      b0 = n_b;
      wr(`DRT_IDX_A_CONTROL, 32'h0D);
      wov(1, c);
      repeat (3) @(posedge pclk);
      rdc(`DRT_IDX_COMB_CNT, 32'h12F0);
      chkb(pin_b, 1'b1);
      wov(0, c);
      repeat (3) @(posedge pclk);
      rdc(`DRT_IDX_COMB_CNT, 32'h1300);
      chk(n_b - b0, 1);
      wr(`DRT_IDX_A_CONTROL, 32'h0);
      wr(`DRT_IDX_B_CONTROL, 32'h0);
      $display("t_wide done");
   endtask
   // Count high cycles of pin A over 40 cycles of a PWM run
   task automatic pwm_run(input [31:0] a, input [31:0] e);
      int hi;
      wr(`DRT_IDX_A_CONTROL, 32'h0);
      wr(`DRT_IDX_A_COUNTER, a);
      wr(`DRT_IDX_B_COUNTER, 32'hFC);
      repeat (20) @(posedge pclk);
      rdc(`DRT_IDX_B_COUNTER, 32'hFC);
      wr(`DRT_IDX_A_CONTROL, 32'h08);
      hi = 0;
      repeat (40) begin
         @(posedge pclk);
         hi += (pin_a === 1'b1);
      end
      chk(hi, e);
   endtask
   task automatic t_pwm;
      wr(`DRT_IDX_B_CONTROL, 32'hA8);
      pwm_run(32'hFE, 32'd20);
      pwm_run(32'hFC, 32'd0);
      wr(`DRT_IDX_A_CONTROL, 32'h0);
      wr(`DRT_IDX_B_CONTROL, 32'h0);
      $display("t_pwm done");
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_regs;
      t_presc;
      t_hold;
      t_event;
      t_wide;
      t_pwm;
      tally_and_finish;
   end
   // Watchdog well past the expected run length
   initial begin
      repeat (40000) @(posedge pclk);
      err_count++;
      tally_and_finish;
   end
endmodule
